// >>> logic/ssp_byte_reg.sv
`timescale 1ns/1ps
`include "ssp_consts.svh"

// One byte register with no reset; content is unknown until first load
module ssp_byte_reg #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk_i, // Core clock
  input  wire logic             we_i,      // Write strobe
  input  wire logic [WIDTH-1:0] d_i,       // Write data
  output logic      [WIDTH-1:0] q_o        // Stored value
);

  // Deliberately no reset: stack bytes are undefined after reset
  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      q_o <= d_i;
    end
  end

endmodule

// >>> logic/ssp_consts.svh
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

// Control-register addresses
`define SSP_ADDR_STACK_UPPER  8'hd8
`define SSP_ADDR_STACK_LOWER  8'hd9
`define SSP_ADDR_SLICE_B      8'hd7
// Slice pointer field layout
`define SSP_SLICE_MSB         7
`define SSP_SLICE_LSB         3
`define SSP_SLICE_LOW_MASK    8'hf8
// Reset value used for the slice pointer field
`define SSP_SLICE_RST         5'h19

`endif

// >>> logic/ssp_pkg.sv
package ssp_pkg;

  // Register access request from the core datapath
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       set_one;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ssp_req_t;

  typedef enum logic [1:0] {
    SSP_IDLE = 2'b01,
    SSP_RESP = 2'b10
  } ssp_state_t;

endpackage

// >>> logic/ssp_regs.sv
`timescale 1ns/1ps
`include "ssp_consts.svh"

// Functional notes
// - Slice pointer B keeps writable 5-bit address
// - Stack upper byte fully read/write
// - Stack address is upper byte joined lower
// - Stack bytes not reset; software loads both
// - Stack upper decodes at d8 in set one
module ssp_regs import ssp_pkg::*; (
  input  wire logic        ref_clk_i,    // Core clock, 250 MHz
  input  wire logic        rst_n_i,      // Async reset, active low
  input  wire ssp_req_t    req_i,        // Register access request
  output logic      [7:0]  rdata_o,      // Read data, registered
  output logic             rvalid_o,     // Read data valid pulse
  output logic      [15:0] stack_addr_o, // Full stack address
  output logic      [4:0]  slice_b_o     // Slice pointer B field
);

  typedef struct packed {
    ssp_state_t state;
    logic [4:0] slice;
    logic [7:0] rdata;
    logic       rvalid;
  } ssp_st_t;

  ssp_st_t    st_q;
  ssp_st_t    st_d;
  logic       hit_upper;
  logic       hit_lower;
  logic       hit_slice;
  logic [7:0] upper_q;
  logic [7:0] lower_q;

  // Address decode; stack bytes only answer in set one
  assign hit_upper = req_i.set_one && (req_i.addr == `SSP_ADDR_STACK_UPPER);
  assign hit_lower = req_i.set_one && (req_i.addr == `SSP_ADDR_STACK_LOWER);
  assign hit_slice = (req_i.addr == `SSP_ADDR_SLICE_B);

  // Stack bytes kept without reset
  ssp_byte_reg #(.WIDTH(8)) u_upper (
    .ref_clk_i (ref_clk_i),
    .we_i      (req_i.wr && hit_upper),
    .d_i       (req_i.wdata),
    .q_o       (upper_q)
  );

  ssp_byte_reg #(.WIDTH(8)) u_lower (
    .ref_clk_i (ref_clk_i),
    .we_i      (req_i.wr && hit_lower),
    .d_i       (req_i.wdata),
    .q_o       (lower_q)
  );

  // Next state: slice write and read mux
  always_comb begin
    st_d        = st_q;
    st_d.rvalid = 1'b0;
    if (req_i.wr && hit_slice) begin
      st_d.slice = req_i.wdata[`SSP_SLICE_MSB:`SSP_SLICE_LSB];
    end
    case (st_q.state)
      SSP_IDLE: begin
        if (req_i.rd) begin
          st_d.rvalid = 1'b1;
          st_d.state  = SSP_RESP;
          if (hit_upper) begin
            st_d.rdata = upper_q;
          end else if (hit_lower) begin
            st_d.rdata = lower_q;
          end else if (hit_slice) begin
            st_d.rdata = {st_q.slice, 3'h0};
          end else begin
            st_d.rdata = 8'h00; // Unmapped reads zero
          end
        end
      end
      SSP_RESP: begin
        st_d.state = SSP_IDLE; // One read per two cycles
      end
      default: begin
        st_d.state = SSP_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '{
        state:  SSP_IDLE,
        slice:  `SSP_SLICE_RST,
        rdata:  8'h00,
        rvalid: 1'b0
      };
    end else begin
      st_q <= st_d;
    end
  end

  // Stack address registered so output comes from a flop
  always_ff @(posedge ref_clk_i) begin
    stack_addr_o <= {upper_q, lower_q};
  end

  assign rdata_o   = st_q.rdata;
  assign rvalid_o  = st_q.rvalid;
  assign slice_b_o = st_q.slice;

  // Checks: one or more per rule, plus read handshake sanity
  // Stack bytes have no reset, so their checks use case equality except the store and write-readback ones

  // Write then immediate read of the upper byte
  upper_rw_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i.wr && hit_upper ##1 (st_q.state == SSP_IDLE && req_i.rd && hit_upper)
      |=> rdata_o == $past(req_i.wdata, 2))
    else $error("upper byte readback mismatch");

  // Joined address follows the bytes one edge later
  join_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    stack_addr_o === $past({upper_q, lower_q}))
    else $error("stack address join wrong");

  // Upper byte ignores writes outside set one
  set_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i.wr && !req_i.set_one && req_i.addr == `SSP_ADDR_STACK_UPPER
      |=> upper_q === $past(upper_q))
    else $error("upper byte written outside set one");

  // Slice field takes the written upper bits
  slice_wr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i.wr && hit_slice |=> slice_b_o == $past(req_i.wdata[7:3]))
    else $error("slice field not stored");

  // Slice low bits always read zero
  slice_low_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $past(req_i.rd && hit_slice && st_q.state == SSP_IDLE) |-> rdata_o[2:0] == 3'h0)
    else $error("slice low bits not zero");

  // Upper byte holds without a write
  no_wr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !(req_i.wr && hit_upper) |=> upper_q === $past(upper_q))
    else $error("upper byte changed without write");

  // Read valid is a single pulse
  rvalid_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rvalid_o |=> !rvalid_o)
    else $error("read valid longer than one cycle");

  // Slice field holds without a write
  slice_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !(req_i.wr && hit_slice) |=> $stable(slice_b_o))
    else $error("slice changed without write");

  // Upper byte stores the written value
  upper_store_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i.wr && hit_upper |=> upper_q == $past(req_i.wdata))
    else $error("upper byte not stored");

  // Lower byte stores the written value
  lower_store_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i.wr && hit_lower |=> lower_q == $past(req_i.wdata))
    else $error("lower byte not stored");

  // Lower byte holds without a write
  lower_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !(req_i.wr && hit_lower) |=> lower_q === $past(lower_q))
    else $error("lower byte changed without write");

  // Lower byte ignores writes outside set one
  lower_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i.wr && !req_i.set_one && req_i.addr == `SSP_ADDR_STACK_LOWER
      |=> lower_q === $past(lower_q))
    else $error("lower byte written outside set one");

  // Upper byte read returns the stored byte
  upper_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i.rd && hit_upper && st_q.state == SSP_IDLE
      |=> rdata_o === $past(upper_q))
    else $error("upper byte read wrong");

  // Slice read returns the stored field on top
  slice_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i.rd && hit_slice && st_q.state == SSP_IDLE
      |=> rdata_o[7:3] == $past(slice_b_o))
    else $error("slice field read wrong");

  // Unmapped reads give zero
  rd_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i.rd && st_q.state == SSP_IDLE && !hit_upper && !hit_lower && !hit_slice
      |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");

  // Every accepted read is answered
  rd_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i.rd && st_q.state == SSP_IDLE |=> rvalid_o)
    else $error("read not answered");

  // A read right after a taken read is refused
  rd_refuse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    st_q.state == SSP_RESP |=> !rvalid_o)
    else $error("read accepted in response cycle");

  // Read data stands until the next answer
  rdata_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !(req_i.rd && st_q.state == SSP_IDLE) |=> $stable(rdata_o))
    else $error("read data changed without read");

  // State stays one-hot
  state_hot_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $onehot(st_q.state))
    else $error("state not one-hot");

  // Main scenarios
  upper_wr_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) req_i.wr && hit_upper);
  slice_rd_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) req_i.rd && hit_slice);
  set_miss_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i.wr && !req_i.set_one && req_i.addr == `SSP_ADDR_STACK_UPPER);
  rd_refused_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    st_q.state == SSP_RESP && req_i.rd);
  wr_rd_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i.wr && hit_upper ##1 req_i.rd && hit_upper);

endmodule

// >>> testbench/stack_and_slice_pointer_regs_tb.sv
`timescale 1ns/1ps
module stack_and_slice_pointer_regs_tb import ssp_pkg::*;;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  ssp_req_t    req_i     = '0;
  logic [7:0]  rdata_o;
  logic        rvalid_o;
  logic [15:0] stack_addr_o;
  logic [4:0]  slice_b_o;
  int          n_errors   = 0;
  int          num_checks = 0;
  // Rows: {set_one, addr, wdata, expected readback}
  logic [24:0] rows [5] = '{25'h1d8a5a5, 25'h1d7fff8, 25'h1d75a58, 25'h0d811a5, 25'h1d93c3c};

  always #2 ref_clk_i = ~ref_clk_i;

  ssp_regs u_dut (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .req_i        (req_i),
    .rdata_o      (rdata_o),
    .rvalid_o     (rvalid_o),
    .stack_addr_o (stack_addr_o),
    .slice_b_o    (slice_b_o)
  );

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle request, launched and dropped at falling edges
  task automatic acc(input logic w, input logic r, input logic s, input logic [7:0] a,
                     input logic [7:0] d);
    @(negedge ref_clk_i);
    req_i = '{wr: w, rd: r, set_one: s, addr: a, wdata: d};
    @(negedge ref_clk_i);
    req_i = '0;
  endtask

  // Read; the pulse is still up at the falling edge after the taken edge
  task automatic rd_chk(input logic s, input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, 1'b1, s, a, 8'h00);
    chk({7'h00, rvalid_o, rdata_o}, {8'h01, e});
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run is a few dozen cycles; this margin only catches a hang
  initial begin
    #20000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    chk({3'h0, slice_b_o, rdata_o}, {3'h0, 5'h19, 8'h00});
    foreach (rows[i]) begin
      acc(1'b1, 1'b0, rows[i][24], rows[i][23:16], rows[i][15:8]);
      rd_chk(1'b1, rows[i][23:16], rows[i][7:0]);
    end
    chk({11'h000, slice_b_o}, 16'h000b);
    chk(stack_addr_o, 16'ha53c);
    rd_chk(1'b0, 8'hd8, 8'h00);
    rd_chk(1'b1, 8'h00, 8'h00);
    // Read held two cycles: the second one must be refused
    @(negedge ref_clk_i);
    req_i = '{wr: 1'b0, rd: 1'b1, set_one: 1'b1, addr: 8'hd8, wdata: 8'h00};
    repeat (2) @(negedge ref_clk_i);
    req_i = '0;
    chk({15'h0000, rvalid_o}, 16'h0000);
    // Write then read the upper byte back to back
    @(negedge ref_clk_i);
    req_i = '{wr: 1'b1, rd: 1'b0, set_one: 1'b1, addr: 8'hd8, wdata: 8'h5c};
    @(negedge ref_clk_i);
    req_i = '{wr: 1'b0, rd: 1'b1, set_one: 1'b1, addr: 8'hd8, wdata: 8'h00};
    @(negedge ref_clk_i);
    req_i = '0;
    chk({7'h00, rvalid_o, rdata_o}, 16'h015c);
    // Mid-run reset leaves the stack bytes alone
    rst_n_i = 1'b0;
    @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    chk(stack_addr_o, 16'h5c3c);
    chk({11'h000, slice_b_o}, 16'h0019);
    tally_and_finish();
  end
endmodule
